// ===== bench/pp_periph.sv
`timescale 1ns/1ps
`default_nettype none
module pp_periph (
    input wire logic clk,
    input wire logic [7:0] port_lines_out,
    input wire logic port_lines_oe,
    input wire logic print_pulse_pin_n,
    input wire logic line_advance_pin_n,
    input wire logic choose_printer_pin_n,
    input wire logic active,
    input wire logic stall,
    input wire logic [1:0] delay,
    input wire logic spp_drive,
    input wire logic [7:0] rd_byte,
    output logic busy_in,
    output logic [7:0] port_lines_in,
    output logic [7:0] got_byte,
    output logic got_addr,
    output logic got_write
);
    logic [1:0] cnt = 2'h0;
    logic drv = 1'b0;
    logic [7:0] float_q = 8'h00;
    wire logic strobe = active && !(line_advance_pin_n && choose_printer_pin_n);
    initial busy_in = 1'b0;
    // released lines must not keep the last level, so each cycle they show the inverse of the cycle before
    always_comb begin
        if (port_lines_oe) begin
            port_lines_in = port_lines_out;
        end else if (drv || spp_drive) begin
            port_lines_in = rd_byte;
        end else begin
            port_lines_in = float_q;
        end
    end
    // hold follows the strobe after a programmable lag; stall never releases it
    always @(posedge clk) begin
        float_q <= ~port_lines_in;
        if (busy_in == strobe) begin
            cnt <= 2'h0;
        end else if (cnt != delay) begin
            cnt <= cnt + 2'h1;
        end else if (!(stall && strobe)) begin
            busy_in <= strobe;
            if (strobe) begin
                drv <= print_pulse_pin_n;
            end
            cnt <= 2'h0;
        end
        if (!strobe) begin
            drv <= 1'b0;
        end
        if (strobe && busy_in) begin
            got_byte <= port_lines_in;
            got_addr <= !choose_printer_pin_n;
            got_write <= !print_pulse_pin_n;
        end
    end
endmodule : pp_periph
`default_nettype wire

// ===== bench/pp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pp_port_tb;
    import pp_pkg::*;
    // short enough for quick stall tests, long enough for the slowest peripheral lag
    localparam int WD = 32;
    typedef struct {string what; logic [7:0] exp; logic [7:0] mask;} pp_note_type;
    pp_note_type notes[$];
    pp_note_type note;
    pp_mode_type mode_sel = PP_MODE_PRINTER;
    pp_mode_type lm[2] = '{PP_MODE_PRINTER, PP_MODE_BIDIR};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic expiry_clear_sel = 1'b0;
    logic io_req = 1'b0;
    logic io_wr = 1'b0;
    logic [2:0] io_addr = 3'h0;
    logic [7:0] io_wdata = 8'h00;
    logic fault_in_n = 1'b1;
    logic online_in = 1'b0;
    logic media_exhausted_in = 1'b0;
    logic char_taken_n = 1'b1;
    logic active = 1'b0;
    logic stall = 1'b0;
    logic [1:0] delay = 2'h0;
    logic spp_drive = 1'b0;
    logic [7:0] rd_byte = 8'h00;
    logic scramble = 1'b0;
    logic io_wait, io_done, port_lines_oe, busy_in, irq, got_addr, got_write;
    logic [7:0] io_rdata, port_lines_out, port_lines_in, got_byte, v, e;
    logic print_pulse_pin_n, line_advance_pin_n, printer_restart_n, choose_printer_pin_n;
    logic [2:0] a;
    int err_total = 0;
    int compares = 0;
    int irq_cnt = 0;
    int cycles = 0;
    int seed;
    always #2 clk = ~clk;
    pp_port #(.WDOG_CYCLES(WD)) uut (.clk(clk), .resetn(resetn), .mode_sel(mode_sel),
        .expiry_clear_sel(expiry_clear_sel), .io_req(io_req), .io_wr(io_wr),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wait(io_wait), .io_done(io_done),
        .io_rdata(io_rdata), .port_lines_in(port_lines_in), .port_lines_out(port_lines_out),
        .port_lines_oe(port_lines_oe), .fault_in_n(fault_in_n), .online_in(online_in),
        .media_exhausted_in(media_exhausted_in), .char_taken_n(char_taken_n),
        .busy_in(busy_in), .print_pulse_pin_n(print_pulse_pin_n),
        .line_advance_pin_n(line_advance_pin_n), .printer_restart_n(printer_restart_n),
        .choose_printer_pin_n(choose_printer_pin_n), .irq(irq));
    pp_periph periph (.clk(clk), .port_lines_out(port_lines_out),
        .port_lines_oe(port_lines_oe), .print_pulse_pin_n(print_pulse_pin_n),
        .line_advance_pin_n(line_advance_pin_n), .choose_printer_pin_n(choose_printer_pin_n),
        .active(active), .stall(stall), .delay(delay), .spp_drive(spp_drive),
        .rd_byte(rd_byte), .busy_in(busy_in), .port_lines_in(port_lines_in),
        .got_byte(got_byte), .got_addr(got_addr), .got_write(got_write));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // one host access; the answer is judged by the monitor against the note
    task automatic io(input logic wr, input logic [2:0] ad, input logic [7:0] d,
            input logic [7:0] ex, input logic [7:0] mask);
        int n;
        pp_note_type nt;
        logic sw;
        nt.what = wr ? "write answer" : "read data";
        nt.exp = ex;
        nt.mask = mask;
        notes.push_back(nt);
        io_req <= 1'b1;
        io_wr <= wr;
        io_addr <= ad;
        io_wdata <= d;
        @(posedge clk);
        io_req <= 1'b0;
        if (scramble) {fault_in_n, online_in, media_exhausted_in, char_taken_n} <= 4'($urandom);
        n = 0;
        sw = 1'b0;
        while (io_done !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
            sw = sw | io_wait;
        end
        if (n >= 40) chk("answer time", 8'h00, 8'h01);
        // only cable cycles may stretch the host access
        chk("wait states", {7'h0, sw},
            {7'h0, ad >= PP_OFF_ADDR_WIN && mode_sel == PP_MODE_ENHANCED});
    endtask : io

    always @(posedge clk) begin
        if (io_done === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected answer", 8'h01, 8'h00);
            end else begin
                note = notes.pop_front();
                chk(note.what, io_rdata & note.mask, note.exp & note.mask);
            end
        end
        if (irq === 1'b1) irq_cnt++;
        cycles++;
        if (cycles == 20000) begin
            chk("cycle limit", 8'h01, 8'h00);
            final_report();
        end
    end

    initial begin
        seed = $urandom(8735);
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset pins", {printer_restart_n, print_pulse_pin_n, line_advance_pin_n,
            choose_printer_pin_n, port_lines_oe, 3'h0}, 8'h78);
        io(0, PP_OFF_DATA, 0, 8'h00, 8'hff);
        io(0, PP_OFF_CONTROL, 0, 8'h00, 8'hff);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            mode_sel <= lm[m];
            for (int i = 0; i < 4; i++) begin
                v = 8'($urandom);
                io(1, PP_OFF_CONTROL, v, 0, 0);
                io(0, PP_OFF_CONTROL, 0, {2'b00, v[5:0]}, 8'hff);
                chk("control pins", {printer_restart_n, print_pulse_pin_n, line_advance_pin_n,
                    choose_printer_pin_n, port_lines_oe, 3'h0},
                    {v[2], ~v[0], ~v[1], ~v[3], m == 0 || !v[5], 3'h0});
            end
        end
        $display("test control done");
        mode_sel <= PP_MODE_PRINTER;
        io(1, PP_OFF_CONTROL, 8'h20, 0, 0);
        v = 8'($urandom);
        io(1, PP_OFF_DATA, v, 0, 0);
        // the line register follows the data register one cycle later
        @(posedge clk);
        chk("data lines", port_lines_out, v);
        io(0, PP_OFF_DATA, 0, v, 8'hff);
        mode_sel <= PP_MODE_BIDIR;
        spp_drive <= 1'b1;
        rd_byte <= 8'($urandom);
        @(posedge clk);
        io(0, PP_OFF_DATA, 0, rd_byte, 8'hff);
        spp_drive <= 1'b0;
        io(1, PP_OFF_DATA_WIN0, 8'h5a, 0, 0);
        io(0, PP_OFF_DATA_WIN0, 0, 8'h00, 8'hff);
        $display("test data done");
        scramble = 1'b1;
        for (int i = 0; i < 6; i++) begin
            {fault_in_n, online_in, media_exhausted_in, char_taken_n} <= 4'($urandom);
            @(posedge clk);
            e = {~busy_in, char_taken_n, media_exhausted_in, online_in, fault_in_n, 3'h0};
            io(0, PP_OFF_STATUS, 0, e, 8'hff);
        end
        scramble = 1'b0;
        char_taken_n <= 1'b1;
        $display("test status done");
        for (int i = 0; i < 2; i++) begin
            io(1, PP_OFF_CONTROL, i ? 8'h00 : 8'h10, 0, 0);
            irq_cnt = 0;
            char_taken_n <= 1'b0;
            repeat (3) @(posedge clk);
            char_taken_n <= 1'b1;
            repeat (4) @(posedge clk);
            chk("irq pulses", irq_cnt[7:0], i ? 8'h00 : 8'h01);
        end
        $display("test irq done");
        mode_sel <= PP_MODE_ENHANCED;
        active <= 1'b1;
        io(1, PP_OFF_CONTROL, 8'h04, 0, 0);
        for (int i = 0; i < 8; i++) begin
            delay <= 2'($urandom);
            a = PP_OFF_ADDR_WIN + 3'($urandom % 5);
            v = 8'($urandom);
            rd_byte <= 8'($urandom);
            io(1, a, v, 0, 0);
            chk("peripheral byte", got_byte, v);
            chk("peripheral kind", {6'h0, got_write, got_addr}, {6'h0, 1'b1, a == 3'h3});
            io(0, a, 0, rd_byte, 8'hff);
        end
        repeat (3) @(posedge clk);
        chk("idle pins", {5'h0, printer_restart_n, print_pulse_pin_n, port_lines_oe}, 8'h07);
        io(1, PP_OFF_CONTROL, 8'h24, 0, 0);
        io(1, PP_OFF_DATA_WIN0, 8'hc3, 0, 0);
        chk("write refused", {7'h0, got_write}, 8'h00);
        io(0, PP_OFF_STATUS, 0, 8'h00, 8'h01);
        // print bit set turns even a read into a write on the cable
        io(1, PP_OFF_CONTROL, 8'h05, 0, 0);
        io(0, PP_OFF_DATA_WIN0, 8'h3c, 0, 0);
        chk("forced write", {7'h0, got_write}, 8'h01);
        io(1, PP_OFF_CONTROL, 8'h04, 0, 0);
        $display("test enhanced done");
        for (int s = 0; s < 2; s++) begin
            expiry_clear_sel <= s[0];
            stall <= 1'b1;
            io(s[0], PP_OFF_DATA_WIN0, 8'h99, 0, 0);
            stall <= 1'b0;
            io(0, PP_OFF_STATUS, 0, 8'h01, 8'h01);
            if (s == 0) begin
                io(1, PP_OFF_STATUS, 8'h00, 0, 0);
                io(0, PP_OFF_STATUS, 0, 8'h01, 8'h01);
                io(1, PP_OFF_STATUS, 8'h01, 0, 0);
            end
            io(0, PP_OFF_STATUS, 0, 8'h00, 8'h01);
        end
        $display("test watchdog done");
        repeat (5) @(posedge clk);
        chk("answers outstanding", 8'(notes.size()), 8'h00);
        final_report();
    end
endmodule : pp_port_tb
`default_nettype wire

// ===== rtl/pp_pkg.sv
package pp_pkg;

    // register offsets inside the eight-byte window
    localparam logic [2:0] PP_OFF_DATA = 3'h0;
    localparam logic [2:0] PP_OFF_STATUS = 3'h1;
    localparam logic [2:0] PP_OFF_CONTROL = 3'h2;
    localparam logic [2:0] PP_OFF_ADDR_WIN = 3'h3;
    localparam logic [2:0] PP_OFF_DATA_WIN0 = 3'h4;

    // status field positions
    localparam int PP_ST_EXPIRED = 0;
    localparam int PP_ST_FAULT = 3;
    localparam int PP_ST_ONLINE = 4;
    localparam int PP_ST_MEDIA = 5;
    localparam int PP_ST_TAKEN = 6;
    localparam int PP_ST_READY = 7;

    // control field positions
    localparam int PP_CT_PRINT = 0;
    localparam int PP_CT_ADVANCE = 1;
    localparam int PP_CT_RESTART = 2;
    localparam int PP_CT_CHOOSE = 3;
    localparam int PP_CT_INT = 4;
    localparam int PP_CT_DIR = 5;
    localparam int PP_CTRL_W = 6;

    localparam logic [7:0] PP_BYTE_RESET = 8'h00;
    localparam logic [PP_CTRL_W-1:0] PP_CTRL_RESET = 6'h00;

    // watchdog: time in ns, clock period in ns, count derived
    localparam int PP_WDOG_TIME_NS = 10000;
    localparam int PP_CLK_PERIOD_NS = 4;
    localparam int PP_WDOG_CYCLES = (PP_WDOG_TIME_NS + PP_CLK_PERIOD_NS - 1) / PP_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PP_MODE_PRINTER,
        PP_MODE_BIDIR,
        PP_MODE_ENHANCED
    } pp_mode_type;

    typedef enum logic [2:0] {
        PP_S_IDLE,
        PP_S_HOLDWAIT,
        PP_S_DRIVE,
        PP_S_STROBE,
        PP_S_FINISH
    } pp_state_type;

endpackage : pp_pkg

// ===== rtl/pp_port.sv
`timescale 1ns/1ps
`default_nettype none
module pp_port #(
    parameter int WDOG_CYCLES = pp_pkg::PP_WDOG_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire pp_pkg::pp_mode_type mode_sel,
    input wire logic expiry_clear_sel,
    input wire logic io_req,
    input wire logic io_wr,
    input wire logic [2:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic io_wait,
    output logic io_done,
    output logic [7:0] io_rdata,
    input wire logic [7:0] port_lines_in,
    output logic [7:0] port_lines_out,
    output logic port_lines_oe,
    input wire logic fault_in_n,
    input wire logic online_in,
    input wire logic media_exhausted_in,
    input wire logic char_taken_n,
    input wire logic busy_in,
    output logic print_pulse_pin_n,
    output logic line_advance_pin_n,
    output logic printer_restart_n,
    output logic choose_printer_pin_n,
    output logic irq
);
    import pp_pkg::*;

    function automatic logic is_window(input logic [2:0] a);
        is_window = (a >= PP_OFF_ADDR_WIN);
    endfunction : is_window

    // the busy pin doubles as the peripheral's hold line in enhanced cycles
    logic periph_hold_n;
    assign periph_hold_n = busy_in;

    pp_state_type state_ff, nxt_state;
    logic [7:0] data_ff, nxt_data;
    logic [7:0] addr_win_ff, nxt_addr_win;
    logic [7:0] data_win_ff, nxt_data_win;
    logic [PP_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic expired_ff, nxt_expired;
    logic [7:0] cyc_byte_ff, nxt_cyc_byte;
    logic cyc_wr_ff, nxt_cyc_wr;
    logic cyc_addr_ff, nxt_cyc_addr;
    logic stat_rd_ff, nxt_stat_rd;
    logic taken_prev_ff, nxt_taken_prev;
    logic io_wait_ff, nxt_io_wait;
    logic io_done_ff, nxt_io_done;
    logic [7:0] io_rdata_ff, nxt_io_rdata;
    logic [7:0] lines_out_ff, nxt_lines_out;
    logic lines_oe_ff, nxt_lines_oe;
    logic print_pin_ff, nxt_print_pin;
    logic advance_pin_ff, nxt_advance_pin;
    logic restart_pin_ff, nxt_restart_pin;
    logic choose_pin_ff, nxt_choose_pin;
    logic irq_ff, nxt_irq;

    logic wdog_run;
    logic wdog_expired;
    logic in_bus;
    logic wr_dir;
    logic strobe_on;
    logic [7:0] status_now;

    assign wdog_run = (state_ff == PP_S_HOLDWAIT) || (state_ff == PP_S_DRIVE)
                      || (state_ff == PP_S_STROBE);

    pp_watchdog #(
        .LIMIT(WDOG_CYCLES)
    ) u_wdog (
        .clk(clk),
        .resetn(resetn),
        .run(wdog_run),
        .expired(wdog_expired)
    );

    always_comb begin
        status_now = 8'h00;
        status_now[PP_ST_EXPIRED] = expired_ff;
        status_now[PP_ST_FAULT] = fault_in_n;
        status_now[PP_ST_ONLINE] = online_in;
        status_now[PP_ST_MEDIA] = media_exhausted_in;
        status_now[PP_ST_TAKEN] = char_taken_n;
        status_now[PP_ST_READY] = ~busy_in;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_data = data_ff;
        nxt_addr_win = addr_win_ff;
        nxt_data_win = data_win_ff;
        nxt_ctrl = ctrl_ff;
        nxt_expired = expired_ff;
        nxt_cyc_byte = cyc_byte_ff;
        nxt_cyc_wr = cyc_wr_ff;
        nxt_cyc_addr = cyc_addr_ff;
        nxt_stat_rd = 1'b0;
        nxt_io_wait = io_wait_ff;
        nxt_io_done = 1'b0;
        nxt_io_rdata = io_rdata_ff;
        nxt_taken_prev = char_taken_n;
        // irq is a one-cycle request per rising edge of the acknowledge pin while the interrupt enable bit is set
        nxt_irq = ctrl_ff[PP_CT_INT] && char_taken_n && !taken_prev_ff;

        unique case (state_ff)
            PP_S_IDLE: begin
                if (io_req) begin
                    if (is_window(io_addr) && mode_sel == PP_MODE_ENHANCED) begin
                        // the written byte is latched for the whole cable cycle
                        nxt_cyc_byte = io_wdata;
                        // with the direction bit set a write degrades to a read
                        nxt_cyc_wr = io_wr && !ctrl_ff[PP_CT_DIR];
                        nxt_cyc_addr = (io_addr == PP_OFF_ADDR_WIN);
                        nxt_io_wait = 1'b1;
                        nxt_state = PP_S_HOLDWAIT;
                    end else begin
                        nxt_io_done = 1'b1;
                        nxt_io_rdata = 8'h00;
                        if (io_wr) begin
                            if (io_addr == PP_OFF_DATA) begin
                                nxt_data = io_wdata;
                            end else if (io_addr == PP_OFF_CONTROL) begin
                                nxt_ctrl = io_wdata[PP_CTRL_W-1:0];
                            end else if (io_addr == PP_OFF_STATUS && !expiry_clear_sel
                                         && io_wdata[PP_ST_EXPIRED]) begin
                                nxt_expired = 1'b0;
                            end
                        end else begin
                            unique case (io_addr)
                                PP_OFF_DATA: nxt_io_rdata = port_lines_in;
                                PP_OFF_STATUS: begin
                                    nxt_io_rdata = status_now;
                                    nxt_stat_rd = 1'b1;
                                end
                                PP_OFF_CONTROL: begin
                                    nxt_io_rdata = {2'b00, ctrl_ff};
                                end
                                // windows read zero outside enhanced mode
                                default: nxt_io_rdata = 8'h00;
                            endcase
                        end
                    end
                end
            end
            PP_S_HOLDWAIT: begin
                // no strobe or direction change until the peripheral holds
                if (!periph_hold_n) begin
                    nxt_state = PP_S_DRIVE;
                end
            end
            PP_S_DRIVE: begin
                // byte and direction settle one cycle ahead of the strobe
                nxt_state = PP_S_STROBE;
            end
            PP_S_STROBE: begin
                if (periph_hold_n) begin
                    nxt_state = PP_S_FINISH;
                end
            end
            PP_S_FINISH: begin
                // strobe pin is still low here, so the capture lands before it rises
                if (!cyc_wr_ff) begin
                    if (cyc_addr_ff) begin
                        nxt_addr_win = port_lines_in;
                    end else begin
                        nxt_data_win = port_lines_in;
                    end
                    nxt_io_rdata = port_lines_in;
                end else begin
                    if (cyc_addr_ff) begin
                        nxt_addr_win = cyc_byte_ff;
                    end else begin
                        nxt_data_win = cyc_byte_ff;
                    end
                end
                nxt_io_wait = 1'b0;
                nxt_io_done = 1'b1;
                nxt_state = PP_S_IDLE;
            end
        endcase

        // abort: strobe drops and the host gets a completion; a read returns whatever the lines carry
        if (wdog_expired && wdog_run) begin
            nxt_state = PP_S_FINISH;
        end

        if (stat_rd_ff && expiry_clear_sel) begin
            nxt_expired = 1'b0;
        end
        // a new expiry wins over any clear in the same cycle
        if (wdog_expired) begin
            nxt_expired = 1'b1;
        end
    end

    // pin drive group
    always_comb begin
        in_bus = (state_ff == PP_S_DRIVE) || (state_ff == PP_S_STROBE)
                 || (state_ff == PP_S_FINISH);
        wr_dir = cyc_wr_ff || ctrl_ff[PP_CT_PRINT];
        strobe_on = (state_ff == PP_S_STROBE);
        nxt_restart_pin = ctrl_ff[PP_CT_RESTART];
        if (in_bus) begin
            // the bus direction flag equals wr_dir; the print pin carries its inverse
            nxt_lines_oe = wr_dir;
            nxt_lines_out = cyc_byte_ff;
            nxt_print_pin = ~wr_dir;
            nxt_advance_pin = ~(strobe_on && !cyc_addr_ff);
            nxt_choose_pin = ~(strobe_on && cyc_addr_ff);
        end else begin
            nxt_lines_oe = (mode_sel == PP_MODE_PRINTER) || !ctrl_ff[PP_CT_DIR];
            nxt_lines_out = data_ff;
            nxt_print_pin = ~ctrl_ff[PP_CT_PRINT];
            nxt_advance_pin = ~ctrl_ff[PP_CT_ADVANCE];
            nxt_choose_pin = ~ctrl_ff[PP_CT_CHOOSE];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= PP_S_IDLE;
            data_ff <= PP_BYTE_RESET;
            addr_win_ff <= PP_BYTE_RESET;
            data_win_ff <= PP_BYTE_RESET;
            ctrl_ff <= PP_CTRL_RESET;
            expired_ff <= 1'b0;
            cyc_byte_ff <= PP_BYTE_RESET;
            cyc_wr_ff <= 1'b0;
            cyc_addr_ff <= 1'b0;
            stat_rd_ff <= 1'b0;
            taken_prev_ff <= 1'b1;
            io_wait_ff <= 1'b0;
            io_done_ff <= 1'b0;
            io_rdata_ff <= PP_BYTE_RESET;
            lines_out_ff <= PP_BYTE_RESET;
            lines_oe_ff <= 1'b0;
            print_pin_ff <= 1'b1;
            advance_pin_ff <= 1'b1;
            restart_pin_ff <= 1'b0;
            choose_pin_ff <= 1'b1;
            irq_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            data_ff <= nxt_data;
            addr_win_ff <= nxt_addr_win;
            data_win_ff <= nxt_data_win;
            ctrl_ff <= nxt_ctrl;
            expired_ff <= nxt_expired;
            cyc_byte_ff <= nxt_cyc_byte;
            cyc_wr_ff <= nxt_cyc_wr;
            cyc_addr_ff <= nxt_cyc_addr;
            stat_rd_ff <= nxt_stat_rd;
            taken_prev_ff <= nxt_taken_prev;
            io_wait_ff <= nxt_io_wait;
            io_done_ff <= nxt_io_done;
            io_rdata_ff <= nxt_io_rdata;
            lines_out_ff <= nxt_lines_out;
            lines_oe_ff <= nxt_lines_oe;
            print_pin_ff <= nxt_print_pin;
            advance_pin_ff <= nxt_advance_pin;
            restart_pin_ff <= nxt_restart_pin;
            choose_pin_ff <= nxt_choose_pin;
            irq_ff <= nxt_irq;
        end
    end

    assign io_wait = io_wait_ff;
    assign io_done = io_done_ff;
    assign io_rdata = io_rdata_ff;
    assign port_lines_out = lines_out_ff;
    assign port_lines_oe = lines_oe_ff;
    assign print_pulse_pin_n = print_pin_ff;
    assign line_advance_pin_n = advance_pin_ff;
    assign printer_restart_n = restart_pin_ff;
    assign choose_printer_pin_n = choose_pin_ff;
    assign irq = irq_ff;

    a_data_write_out: assert property (@(posedge clk) disable iff (!resetn)
        (state_ff == PP_S_IDLE && io_req && io_wr && io_addr == PP_OFF_DATA)
        ##1 (state_ff == PP_S_IDLE) |=> (port_lines_out == $past(io_wdata, 2)))
        else $error("data write not driven on lines");

    a_status_zero_bits: assert property (@(posedge clk) disable iff (!resetn)
        (state_ff == PP_S_IDLE && io_req && !io_wr && io_addr == PP_OFF_STATUS)
        |=> (io_done && io_rdata[2:1] == 2'b00))
        else $error("status bits 1-2 not zero");

    a_ctrl_read_high: assert property (@(posedge clk) disable iff (!resetn)
        (state_ff == PP_S_IDLE && io_req && !io_wr && io_addr == PP_OFF_CONTROL)
        |=> (io_rdata[7:6] == 2'b00))
        else $error("control bits 6-7 not zero");

    a_restart_pin_map: assert property (@(posedge clk) disable iff (!resetn)
        ##1 (printer_restart_n == $past(ctrl_ff[PP_CT_RESTART])))
        else $error("restart pin not following control bit");

    a_irq_gated: assert property (@(posedge clk) disable iff (!resetn)
        irq |-> ($past(ctrl_ff[PP_CT_INT]) && $rose($past(char_taken_n))))
        else $error("irq without enabled rising edge");

    a_printer_lines_out: assert property (@(posedge clk) disable iff (!resetn)
        (mode_sel == PP_MODE_PRINTER && state_ff == PP_S_IDLE) |=> port_lines_oe)
        else $error("printer mode lines not driven");

    a_wdog_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
        (wdog_expired && wdog_run) |=> (expired_ff && state_ff == PP_S_FINISH)
        ##1 io_done)
        else $error("watchdog expiry not flagged or not answered");

    a_hold_no_strobe: assert property (@(posedge clk) disable iff (!resetn)
        (state_ff == PP_S_HOLDWAIT && $past(state_ff) == PP_S_HOLDWAIT)
        |-> (line_advance_pin_n == ~ctrl_ff[PP_CT_ADVANCE]
             && choose_printer_pin_n == ~ctrl_ff[PP_CT_CHOOSE]))
        else $error("strobe changed before hold asserted");

    a_force_write_dir: assert property (@(posedge clk) disable iff (!resetn)
        (state_ff == PP_S_STROBE && ctrl_ff[PP_CT_PRINT])
        |=> (port_lines_oe && !print_pulse_pin_n))
        else $error("print bit did not force write direction");

endmodule : pp_port
`default_nettype wire

// ===== rtl/pp_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module pp_watchdog #(
    parameter int LIMIT = pp_pkg::PP_WDOG_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    output logic expired
);
    import pp_pkg::*;

    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    if (LIMIT < 2) begin : g_chk
        $error("pp_watchdog: LIMIT must be at least 2");
    end

    logic [CW-1:0] count_ff;
    logic [CW-1:0] nxt_count;
    logic expired_ff;
    logic nxt_expired;

    // counter clears whenever the cycle ends, so each cycle gets the full window
    always_comb begin
        nxt_count = '0;
        nxt_expired = 1'b0;
        if (run) begin
            nxt_count = (count_ff == LAST) ? count_ff : count_ff + CW'(1);
            nxt_expired = (count_ff == LAST) && !expired_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= '0;
            expired_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            expired_ff <= nxt_expired;
        end
    end

    assign expired = expired_ff;

endmodule : pp_watchdog
`default_nettype wire
